// ===== uart_rx_buffer_status_bench.sv
// Testbench of the receive status block.
`timescale 1ns/100ps
`include "urxbs_regs.vh"
module uart_rx_buffer_status_bench;
  logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, clkEn = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rv;
  wire pready, frameValid, startDetect, rxDoneIrq;
  wire [10:0] frameBits;
  int nErrors = 0, totalChecks = 0, cyc = 0;
  logic [10:0] fr [4] = '{11'h601, 11'h401, 11'h5FF, 11'h5A5};
  logic [7:0] cc [4] = '{8'h33, 8'h03, 8'h08, 8'h07};
  logic [7:0] es [4] = '{8'h84, 8'h80, 8'h80, 8'h80};
  logic [7:0] ed [4] = '{8'h01, 8'h01, 8'h1F, 8'hA5};
  urxbs_rx_status dut (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .frameValid(frameValid), .frameBits(frameBits),
    .startDetect(startDetect), .rxEnable(), .rxPinOverride(), .rxAbort(), .charSize(),
    .stopTwo(), .rxDoneIrq(rxDoneIrq));
  urxbs_far_tx tx (.clk_sys(clk_sys), .frameValid(frameValid), .frameBits(frameBits),
    .startDetect(startDetect));
  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 2000) begin
    nErrors++;
    stop_test();
  end
  task stop_test();
    if (nErrors == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rv, e);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 0;
    rd(`URXBS_ADDR_CTRLB, 0);
    rd(`URXBS_ADDR_CTRLC, 6);
    apb(1, `URXBS_ADDR_CTRLB, 32'h0000_0090);
    apb(1, `URXBS_ADDR_CTRLC, 32'h0000_0023);
    tx.send(11'h455);
    tx.send(11'h2A3);
    tx.send(11'h433);
    tx.start();
    chk({31'h0, rxDoneIrq}, 1);
    rd(`URXBS_ADDR_STATUS, 32'h0000_0080);
    rd(`URXBS_ADDR_DATA, 32'h0000_0055);
    apb(1, `URXBS_ADDR_STATUS, 0);
    rd(`URXBS_ADDR_STATUS, 32'h0000_0094);
    rd(`URXBS_ADDR_DATA, 32'h0000_00A3);
    rd(`URXBS_ADDR_STATUS, 32'h0000_0088);
    rd(`URXBS_ADDR_DATA, 32'h0000_0033);
    rd(`URXBS_ADDR_STATUS, 0);
    chk({31'h0, rxDoneIrq}, 0);
    for (int i = 0; i < 4; i++) begin
      apb(1, `URXBS_ADDR_CTRLC, {24'h0, cc[i]});
      tx.send(fr[i]);
      rd(`URXBS_ADDR_STATUS, {24'h0, es[i]});
      rd(`URXBS_ADDR_CTRLB, {24'h0, i == 3 ? 8'h92 : 8'h90});
      rd(`URXBS_ADDR_DATA, {24'h0, ed[i]});
    end
    clkEn <= 0;
    tx.send(11'h455);
    clkEn <= 1;
    rd(`URXBS_ADDR_STATUS, 0);
    tx.send(11'h455);
    apb(1, `URXBS_ADDR_CTRLB, 32'h0000_0080);
    rd(`URXBS_ADDR_STATUS, 0);
    rd(12'h020, 0);
    stop_test();
  end
endmodule // uart_rx_buffer_status_bench

// ===== urxbs_far_tx.sv
// Far-end transmitter model handing completed frames to the block.
`timescale 1ns/100ps
module urxbs_far_tx (
  // Clock.
  input wire clk_sys,
  // Frame outputs.
  output logic frameValid = 0,
  output logic [10:0] frameBits = 0,
  output logic startDetect = 0
);
  // One-cycle frame pulse; the bits go stale right after it.
  task send(input logic [10:0] f);
    @(posedge clk_sys);
    frameValid <= 1;
    frameBits <= f;
    @(posedge clk_sys);
    frameValid <= 0;
    frameBits <= ~f;
  endtask
  task start();
    @(posedge clk_sys);
    startDetect <= 1;
    @(posedge clk_sys);
    startDetect <= 0;
  endtask
endmodule // urxbs_far_tx

// ===== urxbs_fifo.v
// Two-entry receive buffer holding characters with their error flags.
`timescale 1ns/100ps
`include "urxbs_regs.vh"
module urxbs_fifo (
  // Clock and control.
  input wire clk_sys,
  input wire reset,
  input wire clkEn,
  input wire flush,
  // Write side.
  input wire wrEn,
  input wire [`URXBS_EN_W-1:0] wrData,
  // Read side.
  input wire rdEn,
  output wire [`URXBS_EN_W-1:0] rdData,
  output wire notEmpty,
  output wire full
);
  reg [`URXBS_EN_W-1:0] mem_ff [0:1];
  reg rdPtr_ff;
  reg wrPtr_ff;
  reg [1:0] count_ff;
  wire doRd;
  wire doWr;
  assign notEmpty = (count_ff != 2'd0);
  assign full = (count_ff == 2'd2);
  assign doRd = rdEn & notEmpty;
  assign doWr = wrEn & (~full | doRd);
  assign rdData = mem_ff[rdPtr_ff];
  always @(posedge clk_sys) begin
    if (reset || (clkEn && flush)) begin
      rdPtr_ff <= 1'b0;
      wrPtr_ff <= 1'b0;
      count_ff <= 2'd0;
    end else if (clkEn) begin
      // Simultaneous read and write both take effect. [RULE_26]
      if (doWr) begin
        mem_ff[wrPtr_ff] <= wrData;
        wrPtr_ff <= ~wrPtr_ff;
      end
      if (doRd) begin
        rdPtr_ff <= ~rdPtr_ff; // [RULE_05]
      end
      count_ff <= count_ff + {1'b0, doWr} - {1'b0, doRd};
    end
  end
endmodule // urxbs_fifo

// ===== urxbs_regs.vh
// Register offsets, bit positions and reset values of the receive status block.
`ifndef URXBS_REGS_VH
`define URXBS_REGS_VH
// Byte offsets on the APB bus.
`define URXBS_ADDR_DATA 12'h000
`define URXBS_ADDR_STATUS 12'h004
`define URXBS_ADDR_CTRLB 12'h008
`define URXBS_ADDR_CTRLC 12'h00C
`define URXBS_ADDR_FRAME 12'h010
`define URXBS_ADDR_MSB 11
// Status register bits.
`define URXBS_ST_PARITY 2
`define URXBS_ST_OVERRUN 3
`define URXBS_ST_FRAME 4
`define URXBS_ST_DONE 7
// Control register B bits.
`define URXBS_CB_NINTH 1
`define URXBS_CB_RXEN 4
`define URXBS_CB_IRQEN 7
// Control register C bits.
`define URXBS_CC_STOP 3
`define URXBS_CC_PODD 4
`define URXBS_CC_PEN 5
`define URXBS_CC_SIZE_LO 0
`define URXBS_CC_SIZE_HI 2
// Frame word bits written by the front end.
`define URXBS_FR_DATA_HI 8
`define URXBS_FR_PAR 9
`define URXBS_FR_STOP 10
// Buffer entry layout: data[8:0], frame, overrun, parity.
`define URXBS_EN_FE 9
`define URXBS_EN_OR 10
`define URXBS_EN_PE 11
`define URXBS_EN_W 12
// Reset values.
`define URXBS_CTRLB_RST 8'h00
`define URXBS_CTRLC_RST 8'h06
`define URXBS_SIZE_9BIT 3'h7
`define URXBS_ZERO32 32'h0000_0000
`endif

// ===== urxbs_rx_status.v
// Receive buffer, error flags, parity check and APB registers of the serial port.
`timescale 1ns/100ps
`include "urxbs_regs.vh"
// Contract
// RULE_01: Done flag high while buffer holds characters.
// RULE_02: Receiver disable flushes buffer, clears done.
// RULE_03: Interrupt is level of flag and enable.
// RULE_04: Handler reads data to retire character.
// RULE_05: Data read pops oldest buffer entry.
// RULE_06: Error flags stored per character, shown oldest.
// RULE_07: Software reads status before data.
// RULE_08: Status writes leave error flags unchanged.
// RULE_09: Software writes zero to error flag positions.
// RULE_10: Error flags raise no interrupt.
// RULE_11: Frame error equals inverted first stop bit.
// RULE_12: Only first stop bit is checked.
// RULE_13: Overrun when full, pending, new start.
// RULE_14: Overrun cleared by successful buffer transfer.
// RULE_15: Parity enable bit gates check; odd select.
// RULE_16: Computed parity compared, mismatch stored per character.
// RULE_17: Parity error zero when checking disabled.
// RULE_18: Flags valid until data register read.
// RULE_19: Disable abandons partial frame immediately.
// RULE_20: Disabled receiver releases pin override.
// RULE_21: Software flushes by reading until done clears.
// RULE_22: Ninth bit per entry, read before data.
// RULE_23: Completed frame moves into buffer at stop.
// RULE_24: Unused upper data bits read zero.
// RULE_25: Parity select zero even, one odd.
// RULE_26: Simultaneous read and write both performed.
module urxbs_rx_status (
  // Clock, reset and clock enable.
  input wire clk_sys,
  input wire reset,
  input wire clkEn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`URXBS_ADDR_MSB:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Front end: completed frame and start bit detection.
  input wire frameValid,
  input wire [10:0] frameBits,
  input wire startDetect,
  // Receiver control toward the front end and pin.
  output wire rxEnable,
  output wire rxPinOverride,
  output wire rxAbort,
  output wire [2:0] charSize,
  output wire stopTwo,
  // Interrupt request.
  output wire rxDoneIrq
);
  reg [7:0] ctrlB_ff;
  reg [7:0] ctrlC_ff;
  reg [`URXBS_EN_W-1:0] pend_ff;
  reg pendValid_ff;
  reg overrun_ff;
  wire [`URXBS_EN_W-1:0] headEntry;
  wire [`URXBS_EN_W-1:0] newEntry;
  wire [`URXBS_EN_W-1:0] capEntry;
  wire rxDisable;
  wire bufNotEmpty;
  wire bufFull;
  wire apbWr;
  wire apbRd;
  wire dataRead;
  wire moveToBuf;
  wire parityErr;
  wire [8:0] maskedData;
  wire [7:0] statusByte;

  // Mask data bits beyond the configured character size.
  function [8:0] size_mask;
    input [2:0] sz;
    begin
      case (sz)
        3'd0: size_mask = 9'h01F;
        3'd1: size_mask = 9'h03F;
        3'd2: size_mask = 9'h07F;
        `URXBS_SIZE_9BIT: size_mask = 9'h1FF;
        default: size_mask = 9'h0FF;
      endcase
    end
  endfunction

  assign apbWr = psel & penable & pwrite & clkEn;
  assign apbRd = psel & penable & ~pwrite & clkEn;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign rxEnable = ctrlB_ff[`URXBS_CB_RXEN];
  assign rxPinOverride = rxEnable; // [RULE_20]
  // Front end must drop any partial frame at once on disable. [RULE_19]
  assign rxAbort = ~rxEnable;
  assign charSize = {ctrlC_ff[`URXBS_CC_SIZE_HI:`URXBS_CC_SIZE_LO]};
  assign stopTwo = ctrlC_ff[`URXBS_CC_STOP];

  // Parity over the data bits, odd select inverts the expected sense. [RULE_16] [RULE_25]
  assign maskedData = frameBits[`URXBS_FR_DATA_HI:0] & size_mask(charSize);
  assign parityErr = ctrlC_ff[`URXBS_CC_PEN] & // [RULE_15] [RULE_17]
    ((^maskedData) ^ ctrlC_ff[`URXBS_CC_PODD] ^ frameBits[`URXBS_FR_PAR]);
  // Checks are made as the frame is taken, with the settings of that moment. [RULE_17]
  // Only the first stop bit is examined. [RULE_11] [RULE_12]
  assign capEntry = {parityErr, 1'b0, ~frameBits[`URXBS_FR_STOP], maskedData};
  // The held frame carries its own results into the buffer. [RULE_06]
  assign newEntry = {pend_ff[`URXBS_EN_PE], overrun_ff, pend_ff[`URXBS_EN_FE:0]};
  // A write that clears the enable flushes at that same edge. [RULE_02] [RULE_19]
  assign rxDisable = ~rxEnable |
    (apbWr & (paddr == `URXBS_ADDR_CTRLB) & ~pwdata[`URXBS_CB_RXEN]);

  assign dataRead = apbRd & (paddr == `URXBS_ADDR_DATA);
  // Frame moves once buffer has room, including room freed this cycle. [RULE_23]
  assign moveToBuf = pendValid_ff & rxEnable & (~bufFull | dataRead);

  urxbs_fifo uBuf (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .flush(rxDisable), // [RULE_02]
    .wrEn(moveToBuf),
    .wrData(newEntry),
    .rdEn(dataRead), // [RULE_05]
    .rdData(headEntry),
    .notEmpty(bufNotEmpty),
    .full(bufFull)
  );

  // Error flags follow the oldest entry. [RULE_06] [RULE_18]
  assign statusByte = {bufNotEmpty, 2'b00, // [RULE_01]
    headEntry[`URXBS_EN_FE] & bufNotEmpty,
    headEntry[`URXBS_EN_OR] & bufNotEmpty,
    headEntry[`URXBS_EN_PE] & bufNotEmpty, 2'b00};
  // Only the done flag feeds the request. [RULE_03] [RULE_10]
  assign rxDoneIrq = bufNotEmpty & ctrlB_ff[`URXBS_CB_IRQEN];

  always @(posedge clk_sys) begin
    if (reset) begin
      ctrlB_ff <= `URXBS_CTRLB_RST;
      ctrlC_ff <= `URXBS_CTRLC_RST;
      pend_ff <= {`URXBS_EN_W{1'b0}};
      pendValid_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else if (clkEn) begin
      // Status writes have no effect on error flags. [RULE_08]
      if (apbWr && paddr == `URXBS_ADDR_CTRLB) begin
        ctrlB_ff <= {pwdata[7:2], ctrlB_ff[`URXBS_CB_NINTH], pwdata[0]};
      end
      if (apbWr && paddr == `URXBS_ADDR_CTRLC) begin
        ctrlC_ff <= pwdata[7:0];
      end
      if (rxDisable) begin
        pendValid_ff <= 1'b0;
        overrun_ff <= 1'b0;
      end else begin
        if (moveToBuf) begin
          pendValid_ff <= 1'b0;
          overrun_ff <= 1'b0; // [RULE_14]
        end
        if (frameValid && (!pendValid_ff || moveToBuf)) begin
          pend_ff <= capEntry;
          pendValid_ff <= 1'b1;
        end
        // A start bit while buffer and shift register are both full. [RULE_13]
        if (startDetect && bufFull && pendValid_ff && !moveToBuf) begin
          overrun_ff <= 1'b1;
        end
      end
    end
  end

  // Read data; the ninth bit rides in control B from the head entry. [RULE_22] [RULE_24]
  always @* begin
    prdata = `URXBS_ZERO32;
    case (paddr)
      `URXBS_ADDR_DATA: prdata = {24'h00_0000, headEntry[7:0]};
      `URXBS_ADDR_STATUS: prdata = {24'h00_0000, statusByte};
      `URXBS_ADDR_CTRLB: prdata = {24'h00_0000, ctrlB_ff[7:2],
        headEntry[`URXBS_FR_DATA_HI] & bufNotEmpty, ctrlB_ff[0]};
      `URXBS_ADDR_CTRLC: prdata = {24'h00_0000, ctrlC_ff};
      default: prdata = `URXBS_ZERO32;
    endcase
  end
endmodule // urxbs_rx_status

// ===== urxbs_rx_status_assertions.sv
// Checker on the ports of the receive status block.
`timescale 1ns/100ps
module urxbs_rx_status_chk (
  // Clock and bus.
  input wire clk_sys,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  // Receiver outputs.
  input wire rxEnable,
  input wire rxPinOverride,
  input wire rxAbort,
  input wire [2:0] charSize,
  input wire stopTwo,
  input wire rxDoneIrq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire acc = psel && penable;
  wire rdAcc = acc && !pwrite;
  property p_pin; rxPinOverride == rxEnable; endproperty
  a_pin: assert property (p_pin) else $error("pin override");
  property p_abort; rxAbort != rxEnable; endproperty
  a_abort: assert property (p_abort) else $error("abort level");
  property p_off; rxDoneIrq |-> rxEnable; endproperty
  a_off: assert property (p_off) else $error("irq while off");
  property p_hi; rdAcc && paddr == 12'h000 |-> prdata[31:8] == 0; endproperty
  a_hi: assert property (p_hi) else $error("data high bits");
  property p_flag; rdAcc && paddr == 12'h004 && rxDoneIrq |-> prdata[7]; endproperty
  a_flag: assert property (p_flag) else $error("irq without flag");
  property p_hold; rxDoneIrq && !acc |=> rxDoneIrq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_fall; $fell(rxDoneIrq) |-> $past(acc); endproperty
  a_fall: assert property (p_fall) else $error("irq fell alone");
  property p_en; rdAcc && paddr == 12'h008 |-> prdata[4] == rxEnable; endproperty
  a_en: assert property (p_en) else $error("enable readback");
  property p_flush; rdAcc && paddr == 12'h004 && !rxEnable |-> !prdata[7]; endproperty
  a_flush: assert property (p_flush) else $error("done while off");
  property p_size;
    rdAcc && paddr == 12'h00C |-> prdata[2:0] == charSize && prdata[3] == stopTwo;
  endproperty
  a_size: assert property (p_size) else $error("format outputs");
endmodule // urxbs_rx_status_chk
bind urxbs_rx_status urxbs_rx_status_chk u_chk (.*);
